// file: core/ovseq_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "ovseq_defs.svh"
module ovseq_core
#(
  parameter int          BCW          = 16,
  parameter logic [15:0] RELEASE_USEC = 16'(`OVSEQ_RELEASE_US)
) (
  // Clock and reset.
  input  wire logic           sys_clk,
  input  wire logic           rst_n,
  input  wire logic           clk_en,
  // Task file write and read port.
  input  wire logic           tf_wr,
  input  wire logic [2:0]     tf_addr,
  input  wire logic [7:0]     tf_wdata,
  input  wire logic           tf_rd,
  // Task file read data, byte count and identify word 71.
  output logic [7:0]          tf_rdata,
  output logic [BCW-1:0]      byte_count,
  output logic [15:0]         identify_word71,
  // Data phase.
  input  wire logic           word_done,
  output logic                dmarq,
  // Command engine.
  input  wire logic           eng_ready,
  input  wire logic           queue_full,
  input  wire logic           cmd_ok,
  input  wire logic           data_ready,
  input  wire logic           data_dir_in,
  input  wire logic           status_ready,
  input  wire logic           more_data,
  input  wire logic [BCW-1:0] eng_bcnt,
  input  wire logic           int_on_release,
  input  wire logic           int_on_service,
  input  wire logic           error_in,
  // Engine view of the command.
  output logic                overlapped_cmd,
  output logic [6:0]          cmd_tag,
  output logic                cmd_dma,
  output ovseq_pkg::ovseq_state_t state,
  // Host signals.
  output logic                intrq,
  output logic                cmd_or_data,
  output logic                direction
);
  import ovseq_pkg::*;

  localparam logic [15:0] LAST_WORD_CYC = 16'(`OVSEQ_LAST_WORD_CYC);
  localparam logic [15:0] RELEASE_CYC   = 16'(RELEASE_USEC * 16'(`OVSEQ_CLK_MHZ));

  ovseq_state_t   state_q;
  logic           busy_q;
  logic           drq_q;
  logic           release_q;
  logic           service_q;
  logic           dma_ready_q;
  logic           cod_q;
  logic           io_q;
  logic           intrq_q;
  logic           dmarq_q;
  logic           accept_q;
  logic           err_q;
  logic           pend_q;
  logic [7:0]     feature_q;
  logic [BCW-1:0] bcnt_q;
  logic           tmr_start;
  logic [15:0]    tmr_count;
  logic           tmr_exp;

  function automatic logic is_ovl_ata(input logic [7:0] code);
    return code == `OVSEQ_CMD_READ_OVL || code == `OVSEQ_CMD_WRITE_OVL;
  endfunction

  wire cmd_wr  = tf_wr && tf_addr == `OVSEQ_REG_COMMAND;
  wire svc_cmd = cmd_wr && tf_wdata == `OVSEQ_CMD_SERVICE;

  ovseq_timer #(.CW(16)) u_timer (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .start   (tmr_start),
    .stop    (1'b0),
    .count   (tmr_count),
    .running (),
    .expired (tmr_exp)
  );

  assign identify_word71 = RELEASE_USEC;

  // Feature register is write only; held for the engine.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      feature_q <= `OVSEQ_FEATURE_RST;
    end else if (clk_en && tf_wr && tf_addr == `OVSEQ_REG_FEATURE && !busy_q) begin
      feature_q <= tf_wdata;
    end
  end

  // Overlap decision taken when a command is written.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      overlapped_cmd <= 1'b0;
      cmd_tag        <= 7'h00;
      cmd_dma        <= 1'b0;
    end else if (clk_en && cmd_wr && state_q == OVSEQ_IDLE) begin
      if (tf_wdata == `OVSEQ_CMD_PACKET) begin
        overlapped_cmd <= feature_q[`OVSEQ_FT_OVL_EN];
        cmd_dma        <= feature_q[`OVSEQ_FT_DMA];
        cmd_tag        <= 7'h00;
      end else begin
        overlapped_cmd <= is_ovl_ata(tf_wdata);
        cmd_tag        <= feature_q[`OVSEQ_FT_TAG_MSB:`OVSEQ_FT_TAG_LSB];
        cmd_dma        <= feature_q[`OVSEQ_FT_DMA];
      end
    end
  end

  // Accept-ready is clear out of reset and follows the engine and queue.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      accept_q <= 1'b0;
      err_q    <= 1'b0;
    end else if (clk_en) begin
      accept_q <= eng_ready && !queue_full;
      err_q    <= error_in;
    end
  end

  // Sequencer. Each transition that sets pend_q takes two cycles: the first shows busy with the
  // phase bits, the second drops busy, so the host never sees a half-built state.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= OVSEQ_IDLE;
      busy_q      <= 1'b0;
      drq_q       <= 1'b0;
      release_q   <= 1'b0;
      service_q   <= 1'b0;
      dma_ready_q <= 1'b0;
      cod_q       <= 1'b0;
      io_q        <= 1'b0;
      intrq_q     <= 1'b0;
      dmarq_q     <= 1'b0;
      pend_q      <= 1'b0;
      bcnt_q      <= `OVSEQ_BCNT_RST;
      tmr_start   <= 1'b0;
      tmr_count   <= 16'h0000;
    end else if (clk_en) begin
      tmr_start <= 1'b0;
      if (tf_rd && tf_addr == `OVSEQ_REG_STATUS) begin
        intrq_q <= 1'b0;
      end
      if (pend_q) begin
        busy_q <= 1'b0;
        pend_q <= 1'b0;
      end else begin
        case (state_q)
          OVSEQ_IDLE: begin
            if (cmd_wr && tf_wdata == `OVSEQ_CMD_PACKET) begin
              busy_q  <= 1'b1;
              cod_q   <= 1'b1;
              io_q    <= 1'b0;
              drq_q   <= 1'b1;
              pend_q  <= 1'b1;
              state_q <= OVSEQ_CMD_PACKET;
            end
          end
          OVSEQ_CMD_PACKET: begin
            if (cmd_ok) begin
              busy_q    <= 1'b1;
              drq_q     <= 1'b0;
              cod_q     <= 1'b0;
              tmr_start <= 1'b1;
              tmr_count <= RELEASE_CYC;
              if (data_ready) begin
                io_q      <= data_dir_in;
                release_q <= 1'b0;
                bcnt_q    <= eng_bcnt;
                drq_q     <= 1'b1;
                intrq_q   <= 1'b1;
                pend_q    <= 1'b1;
                state_q   <= OVSEQ_DATA;
              end else begin
                io_q      <= 1'b0;
                release_q <= 1'b1;
                intrq_q   <= int_on_release;
                pend_q    <= 1'b1;
                state_q   <= OVSEQ_RELEASE;
              end
            end
          end
          OVSEQ_DATA: begin
            if (word_done && bcnt_q <= BCW'(2)) begin
              bcnt_q    <= '0;
              tmr_start <= 1'b1;
              tmr_count <= LAST_WORD_CYC;
              if (more_data) begin
                busy_q  <= 1'b1;
                drq_q   <= 1'b0;
                state_q <= OVSEQ_SERVICE;
              end else if (status_ready) begin
                busy_q    <= 1'b1;
                release_q <= 1'b0;
                drq_q     <= 1'b0;
                dmarq_q   <= 1'b0;
                cod_q     <= 1'b1;
                io_q      <= 1'b1;
                state_q   <= OVSEQ_STATUS;
              end else begin
                release_q <= 1'b1;
                drq_q     <= 1'b0;
                dmarq_q   <= 1'b0;
                state_q   <= OVSEQ_RELEASE;
              end
            end else if (word_done) begin
              bcnt_q <= bcnt_q - BCW'(2);
            end
          end
          OVSEQ_RELEASE: begin
            // Raised once per request, so a status read can still drop the interrupt.
            if ((data_ready || status_ready) && !service_q) begin
              service_q   <= 1'b1;
              dma_ready_q <= data_ready && cmd_dma;
              intrq_q     <= 1'b1;
            end
            if (svc_cmd && service_q) begin
              service_q <= 1'b0;
              busy_q    <= 1'b1;
              release_q <= 1'b0;
              pend_q    <= 1'b1;
              intrq_q   <= int_on_service;
              if (data_ready) begin
                io_q    <= data_dir_in;
                cod_q   <= 1'b0;
                bcnt_q  <= eng_bcnt;
                drq_q   <= !dma_ready_q;
                dmarq_q <= dma_ready_q;
                state_q <= OVSEQ_DATA;
              end else begin
                io_q    <= 1'b1;
                cod_q   <= 1'b1;
                drq_q   <= 1'b0;
                state_q <= OVSEQ_STATUS;
              end
            end
          end
          OVSEQ_SERVICE: begin
            // Reused as the busy gap between two byte counts of one transfer.
            if (data_ready) begin
              bcnt_q  <= eng_bcnt;
              drq_q   <= 1'b1;
              intrq_q <= 1'b1;
              pend_q  <= 1'b1;
              state_q <= OVSEQ_DATA;
            end
          end
          OVSEQ_STATUS: begin
            if (busy_q && status_ready) begin
              busy_q  <= 1'b0;
              intrq_q <= 1'b1;
            end else if (!busy_q && tf_rd && tf_addr == `OVSEQ_REG_STATUS) begin
              cod_q   <= 1'b0;
              io_q    <= 1'b0;
              dma_ready_q <= 1'b0;
              state_q <= OVSEQ_IDLE;
            end
          end
          default: state_q <= OVSEQ_IDLE;
        endcase
      end
    end
  end

  always_comb begin
    tf_rdata = 8'h00;
    if (tf_addr == `OVSEQ_REG_STATUS) begin
      tf_rdata[`OVSEQ_ST_BUSY]      = busy_q;
      tf_rdata[`OVSEQ_ST_ACCEPT]    = accept_q;
      tf_rdata[`OVSEQ_ST_DMA_READY] = dma_ready_q;
      tf_rdata[`OVSEQ_ST_SERVICE]   = service_q;
      tf_rdata[`OVSEQ_ST_DRQ]       = drq_q;
      tf_rdata[`OVSEQ_ST_ERROR]     = err_q;
    end else if (tf_addr == `OVSEQ_REG_BCNT_LO) begin
      tf_rdata = bcnt_q[7:0];
    end else if (tf_addr == `OVSEQ_REG_BCNT_HI) begin
      tf_rdata = bcnt_q[15:8];
    end
  end

  assign byte_count  = bcnt_q;
  assign dmarq       = dmarq_q;
  assign state       = state_q;
  assign intrq       = intrq_q;
  assign cmd_or_data = cod_q;
  assign direction   = io_q;

  // The service flag, once set, holds until a service command is written.
  service_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && service_q && !svc_cmd |=> service_q)
    else $error("service flag dropped without service command");

  // A packet command from idle shows busy then the packet phase with data request.
  sequence packet_entry_s;
    busy_q && cod_q && !io_q && drq_q ##1 !busy_q && drq_q;
  endsequence
  packet_entry_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && state_q == OVSEQ_IDLE && cmd_wr && tf_wdata == `OVSEQ_CMD_PACKET && !pend_q |=> packet_entry_s)
    else $error("packet entry sequence wrong");

  // Entering release clears the data request and shows relinquish.
  release_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(release_q) |-> !drq_q && !dmarq_q)
    else $error("release with data request set");

  // Status bit 7 always mirrors the busy flag.
  busy_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tf_addr == `OVSEQ_REG_STATUS |-> tf_rdata[7] == busy_q)
    else $error("status bit 7 does not show busy");

  // Accept-ready is clear the cycle after an enabled cycle with the queue full.
  accept_full_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && queue_full |=> !accept_q)
    else $error("accept ready set with full queue");

  // Status phase shows both phase bits and no data request.
  status_phase_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == OVSEQ_STATUS |-> cod_q && io_q && !drq_q && !release_q)
    else $error("status phase bits wrong");

  // A non-overlapped code other than the packet command never sets the overlapped mark.
  ata_overlap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && cmd_wr && state_q == OVSEQ_IDLE && tf_wdata != `OVSEQ_CMD_PACKET && !is_ovl_ata(tf_wdata)
    |=> !overlapped_cmd)
    else $error("non-overlapped command marked overlapped");

  // Leaving data for another count re-requests data after the busy gap.
  reload_drq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && state_q == OVSEQ_SERVICE && data_ready && !pend_q |=> busy_q && drq_q ##1 !busy_q)
    else $error("further transfer sequence wrong");

  // The busy gap between two byte counts must end before the last-word window runs out.
  reload_window_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == OVSEQ_SERVICE |-> !tmr_exp)
    else $error("data request not renewed in time");
endmodule
`default_nettype wire

// file: core/ovseq_defs.svh
`ifndef OVSEQ_DEFS_SVH
`define OVSEQ_DEFS_SVH

// Task file register indices on the device's register port.
`define OVSEQ_REG_FEATURE      3'h1
`define OVSEQ_REG_BCNT_LO      3'h4
`define OVSEQ_REG_BCNT_HI      3'h5
`define OVSEQ_REG_COMMAND      3'h7
`define OVSEQ_REG_STATUS       3'h7

// Status bit positions.
`define OVSEQ_ST_BUSY          7
`define OVSEQ_ST_ACCEPT        6
`define OVSEQ_ST_DMA_READY     5
`define OVSEQ_ST_SERVICE       4
`define OVSEQ_ST_DRQ           3
`define OVSEQ_ST_CORRECTED_ERROR_FLAG          2
`define OVSEQ_ST_INDEX         1
`define OVSEQ_ST_ERROR         0

// Feature register fields.
`define OVSEQ_FT_TAG_MSB       7
`define OVSEQ_FT_TAG_LSB       1
`define OVSEQ_FT_DMA           0
`define OVSEQ_FT_OVL_EN        1

// Command codes.
`define OVSEQ_CMD_PACKET       8'ha0
`define OVSEQ_CMD_SERVICE      8'ha2
`define OVSEQ_CMD_READ_OVL     8'hc7
`define OVSEQ_CMD_WRITE_OVL    8'hcc

// Reset values.
`define OVSEQ_FEATURE_RST      8'h00
`define OVSEQ_BCNT_RST         16'h0000

// Timing.
`define OVSEQ_CLK_MHZ          50
`define OVSEQ_LAST_WORD_NS     5000
`define OVSEQ_LAST_WORD_CYC    ((`OVSEQ_LAST_WORD_NS * `OVSEQ_CLK_MHZ) / 1000)
`define OVSEQ_RELEASE_US       2

`endif

// file: core/ovseq_pkg.sv
package ovseq_pkg;
  typedef enum logic [2:0] {
    OVSEQ_IDLE,
    OVSEQ_CMD_PACKET,
    OVSEQ_RELEASE,
    OVSEQ_DATA,
    OVSEQ_SERVICE,
    OVSEQ_STATUS
  } ovseq_state_t;
endpackage

// file: core/ovseq_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Down counter that reports expiry once the armed interval has run out.
module ovseq_timer #(
  parameter int CW = 16
) (
  // Clock and reset.
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          clk_en,
  // Control.
  input  wire logic          start,
  input  wire logic          stop,
  input  wire logic [CW-1:0] count,
  // Result.
  output logic               running,
  output logic               expired
);
  logic [CW-1:0] cnt_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q   <= '0;
      running <= 1'b0;
    end else if (clk_en) begin
      if (start) begin
        cnt_q   <= count;
        running <= 1'b1;
      end else if (stop || cnt_q == '0) begin
        running <= 1'b0;
      end else if (running) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign expired = running && cnt_q == '0;
endmodule
`default_nettype wire

// file: tb/overlapped_task_file_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ovseq_defs.svh"
module overlapped_task_file_sequencer_bench;
  import ovseq_pkg::*;
  logic         sys_clk, rst_n, tf_wr, tf_rd, word_done, dmarq, intrq, cmd_or_data, direction;
  logic         eng_ready, queue_full, cmd_ok, data_ready, data_dir_in, status_ready, more_data;
  logic         int_on_release, int_on_service, overlapped_cmd, cmd_dma, clk_en;
  logic [2:0]   tf_addr;
  logic [7:0]   tf_wdata, tf_rdata, rd;
  logic [15:0]  byte_count, identify_word71, eng_bcnt;
  logic [6:0]   cmd_tag;
  ovseq_state_t state;
  int           fails, n_checks;

  ovseq_core dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .tf_wr(tf_wr), .tf_addr(tf_addr),
    .tf_wdata(tf_wdata), .tf_rd(tf_rd), .tf_rdata(tf_rdata), .byte_count(byte_count),
    .identify_word71(identify_word71), .word_done(word_done), .dmarq(dmarq), .eng_ready(eng_ready),
    .queue_full(queue_full), .cmd_ok(cmd_ok), .data_ready(data_ready), .data_dir_in(data_dir_in),
    .status_ready(status_ready), .more_data(more_data), .eng_bcnt(eng_bcnt),
    .int_on_release(int_on_release), .int_on_service(int_on_service), .error_in(1'b0),
    .overlapped_cmd(overlapped_cmd), .cmd_tag(cmd_tag), .cmd_dma(cmd_dma), .state(state),
    .intrq(intrq), .cmd_or_data(cmd_or_data), .direction(direction));
  ovseq_host_model host (.sys_clk(sys_clk), .tf_wr(tf_wr), .tf_addr(tf_addr), .tf_wdata(tf_wdata),
    .tf_rd(tf_rd), .tf_rdata(tf_rdata));

  always #10 sys_clk = ~sys_clk;

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_st(input ovseq_state_t s, input int n);
    for (int i = 0; i < n && state !== s; i++) @(negedge sys_clk);
  endtask

  // Polls a status bit while the host model rests its address on status.
  task automatic wait_bit(input int b, input logic v, input int n);
    for (int i = 0; i < n && tf_rdata[b] !== v; i++) @(negedge sys_clk);
  endtask

  task automatic words(input int n);
    repeat (n) begin
      @(negedge sys_clk) word_done = 1'b1;
      @(negedge sys_clk) word_done = 1'b0;
    end
  endtask

  task automatic packet(input logic [7:0] feat);
    host.write_reg(`OVSEQ_REG_FEATURE, feat);
    host.write_reg(`OVSEQ_REG_COMMAND, `OVSEQ_CMD_PACKET);
    wait_bit(`OVSEQ_ST_BUSY, 1'b1, 3);
    chk("busy on packet", 16'(tf_rdata[`OVSEQ_ST_BUSY]), 16'h1);
    wait_bit(`OVSEQ_ST_BUSY, 1'b0, 4);
    chk("packet status", 16'(tf_rdata & 8'h88), 16'h0008);
    chk("packet phase", {14'h0, cmd_or_data, direction}, 16'h2);
    chk("packet overlap", {14'h0, overlapped_cmd, cmd_dma}, {15'h1, feat[0]});
  endtask

  task automatic t_reset();
    chk("status after reset", 16'(tf_rdata), 16'h0000);
    chk("word 71", identify_word71, 16'(`OVSEQ_RELEASE_US));
    @(negedge sys_clk) eng_ready = 1'b1;
    wait_bit(`OVSEQ_ST_ACCEPT, 1'b1, 4);
    chk("accept ready", 16'(tf_rdata[`OVSEQ_ST_ACCEPT]), 16'h1);
    @(negedge sys_clk) queue_full = 1'b1;
    wait_bit(`OVSEQ_ST_ACCEPT, 1'b0, 4);
    chk("accept when full", 16'(tf_rdata[`OVSEQ_ST_ACCEPT]), 16'h0);
    @(negedge sys_clk) {clk_en, queue_full} = 2'b00;
    repeat (3) @(negedge sys_clk);
    chk("accept frozen", 16'(tf_rdata[`OVSEQ_ST_ACCEPT]), 16'h0);
    clk_en = 1'b1;
    wait_bit(`OVSEQ_ST_ACCEPT, 1'b1, 4);
    chk("accept thawed", 16'(tf_rdata[`OVSEQ_ST_ACCEPT]), 16'h1);
  endtask

  // Packet straight into data, a reload, a release, then service with data and final status.
  task automatic t_data_path();
    packet(8'h02);
    @(negedge sys_clk);
    {cmd_ok, data_ready, data_dir_in, more_data, eng_bcnt} = {4'hf, 16'h0004};
    wait_st(OVSEQ_DATA, 100);
    wait_bit(`OVSEQ_ST_DRQ, 1'b1, 100);
    wait_bit(`OVSEQ_ST_BUSY, 1'b0, 4);
    chk("data status", 16'(tf_rdata & 8'h88), 16'h0008);
    chk("data phase", {13'h0, intrq, cmd_or_data, direction}, 16'h5);
    chk("data count", byte_count, 16'h0004);
    cmd_ok = 1'b0;
    eng_bcnt = 16'h0006;
    host.read_reg(`OVSEQ_REG_STATUS, rd);
    words(2);
    wait_bit(`OVSEQ_ST_DRQ, 1'b0, 6);
    wait_bit(`OVSEQ_ST_DRQ, 1'b1, 240);
    wait_bit(`OVSEQ_ST_BUSY, 1'b0, 4);
    chk("reload drq", 16'(tf_rdata & 8'h88), 16'h0008);
    chk("reload count", byte_count, 16'h0006);
    chk("reload intrq", 16'(intrq), 16'h1);
    host.read_reg(`OVSEQ_REG_STATUS, rd);
    {data_ready, more_data} = 2'b00;
    words(3);
    wait_st(OVSEQ_RELEASE, 250);
    chk("release state", 16'(state), 16'(OVSEQ_RELEASE));
    chk("release status", 16'(tf_rdata & 8'h88), 16'h0000);
    chk("release phase", {13'h0, intrq, cmd_or_data, direction}, 16'h1);
    {data_ready, int_on_service, eng_bcnt} = {2'b11, 16'h0008};
    wait_bit(`OVSEQ_ST_SERVICE, 1'b1, 50);
    chk("service request", 16'(tf_rdata & 8'h30), 16'h0010);
    chk("service intrq", 16'(intrq), 16'h1);
    host.read_reg(`OVSEQ_REG_STATUS, rd);
    chk("service held", 16'(tf_rdata[`OVSEQ_ST_SERVICE]), 16'h1);
    host.service();
    wait_bit(`OVSEQ_ST_DRQ, 1'b1, 100);
    wait_bit(`OVSEQ_ST_BUSY, 1'b0, 4);
    chk("service data", 16'(tf_rdata & 8'h98), 16'h0008);
    chk("service phase", {13'h0, intrq, cmd_or_data, direction}, 16'h5);
    chk("service count", byte_count, 16'h0008);
    host.read_reg(`OVSEQ_REG_STATUS, rd);
    {data_ready, status_ready} = 2'b01;
    words(4);
    wait_st(OVSEQ_STATUS, 250);
    wait_bit(`OVSEQ_ST_BUSY, 1'b0, 4);
    chk("final status", 16'(tf_rdata & 8'h88), 16'h0000);
    chk("final phase", {13'h0, intrq, cmd_or_data, direction}, 16'h7);
    chk("final dma", 16'(dmarq), 16'h0);
    host.read_reg(`OVSEQ_REG_STATUS, rd);
    status_ready = 1'b0;
    wait_st(OVSEQ_IDLE, 4);
    chk("back to idle", 16'(state), 16'(OVSEQ_IDLE));
  endtask

  // Packet with DMA, released with an interrupt, then serviced with status only.
  task automatic t_release_path();
    packet(8'h03);
    @(negedge sys_clk);
    {cmd_ok, data_ready, data_dir_in, int_on_release} = 4'b1001;
    wait_st(OVSEQ_RELEASE, 100);
    wait_bit(`OVSEQ_ST_BUSY, 1'b0, 4);
    chk("release state", 16'(state), 16'(OVSEQ_RELEASE));
    chk("release status", 16'(tf_rdata & 8'h88), 16'h0000);
    chk("release phase", {13'h0, intrq, cmd_or_data, direction}, 16'h4);
    cmd_ok = 1'b0;
    host.read_reg(`OVSEQ_REG_STATUS, rd);
    status_ready = 1'b1;
    wait_bit(`OVSEQ_ST_SERVICE, 1'b1, 50);
    chk("status service", 16'(intrq), 16'h1);
    host.service();
    wait_st(OVSEQ_STATUS, 100);
    wait_bit(`OVSEQ_ST_BUSY, 1'b0, 4);
    chk("status only", 16'(tf_rdata & 8'h98), 16'h0000);
    chk("status phase", {14'h0, cmd_or_data, direction}, 16'h3);
    host.read_reg(`OVSEQ_REG_STATUS, rd);
    status_ready = 1'b0;
    wait_st(OVSEQ_IDLE, 4);
  endtask

  // Packet with DMA released without data, then serviced by DMA into final status.
  task automatic t_dma_path();
    packet(8'h03);
    @(negedge sys_clk) cmd_ok = 1'b1;
    wait_st(OVSEQ_RELEASE, 100);
    cmd_ok = 1'b0;
    host.read_reg(`OVSEQ_REG_STATUS, rd);
    {data_ready, data_dir_in, eng_bcnt} = {2'b11, 16'h0004};
    wait_bit(`OVSEQ_ST_SERVICE, 1'b1, 50);
    chk("dma ready", 16'(tf_rdata & 8'h30), 16'h0030);
    host.service();
    wait_bit(`OVSEQ_ST_BUSY, 1'b0, 4);
    chk("dma service", {12'h0, dmarq, tf_rdata[`OVSEQ_ST_DMA_READY], tf_rdata[`OVSEQ_ST_DRQ], cmd_or_data}, 16'h000c);
    {data_ready, status_ready} = 2'b01;
    words(2);
    wait_st(OVSEQ_STATUS, 250);
    chk("dma stop", 16'(dmarq), 16'h0);
    wait_bit(`OVSEQ_ST_BUSY, 1'b0, 4);
    host.read_reg(`OVSEQ_REG_STATUS, rd);
    status_ready = 1'b0;
    wait_st(OVSEQ_IDLE, 4);
    chk("dma ready idle", 16'(tf_rdata[`OVSEQ_ST_DMA_READY]), 16'h0);
  endtask

  task automatic t_ata_overlap();
    host.write_reg(`OVSEQ_REG_FEATURE, 8'h03);
    host.write_reg(`OVSEQ_REG_COMMAND, 8'h20);
    repeat (3) @(negedge sys_clk);
    chk("plain command", 16'(overlapped_cmd), 16'h0);
    wait_bit(`OVSEQ_ST_BUSY, 1'b0, 20);
    host.write_reg(`OVSEQ_REG_FEATURE, 8'hb5);
    host.write_reg(`OVSEQ_REG_COMMAND, `OVSEQ_CMD_READ_OVL);
    repeat (3) @(negedge sys_clk);
    chk("overlapped read", 16'(overlapped_cmd), 16'h1);
    chk("tag and dma", {8'h0, cmd_tag, cmd_dma}, 16'h00b5);
  endtask

  task automatic end_sim();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    {sys_clk, rst_n, word_done, eng_ready, queue_full, cmd_ok, data_ready} = 7'h00;
    {data_dir_in, status_ready, more_data, int_on_release, int_on_service} = 5'h00;
    eng_bcnt = 16'h0000;
    clk_en   = 1'b1;
    fails    = 0;
    n_checks = 0;
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    t_reset();
    t_data_path();
    t_release_path();
    t_dma_path();
    t_ata_overlap();
    end_sim();
  end

  // The whole sequence needs little more than a hundred cycles; this leaves ample margin.
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    end_sim();
  end
endmodule
`default_nettype wire

// file: tb/ovseq_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "ovseq_defs.svh"
// Host side of the task file: one register access at a time, changed at the falling edge.
module ovseq_host_model (
  // Clock.
  input  wire logic       sys_clk,
  // Task file.
  output logic            tf_wr,
  output logic [2:0]      tf_addr,
  output logic [7:0]      tf_wdata,
  output logic            tf_rd,
  input  wire logic [7:0] tf_rdata
);
  // Between accesses the address rests on status so the bench can watch it without a read.
  initial begin
    tf_wr    = 1'b0;
    tf_rd    = 1'b0;
    tf_addr  = `OVSEQ_REG_STATUS;
    tf_wdata = 8'h00;
  end

  task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    tf_addr  = a;
    tf_wdata = d;
    tf_wr    = 1'b1;
    @(negedge sys_clk);
    tf_wr    = 1'b0;
    tf_addr  = `OVSEQ_REG_STATUS;
    tf_wdata = ~d;
  endtask

  // A status read also clears the pending interrupt.
  task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    tf_addr = a;
    tf_rd   = 1'b1;
    @(posedge sys_clk);
    d = tf_rdata;
    @(negedge sys_clk);
    tf_rd   = 1'b0;
    tf_addr = `OVSEQ_REG_STATUS;
  endtask

  // Other registers are only trusted once the service command has gone out.
  task automatic service();
    write_reg(`OVSEQ_REG_COMMAND, `OVSEQ_CMD_SERVICE);
  endtask
endmodule
`default_nettype wire
